// [status_flag_logic.sv]
`timescale 1ns/1ps
// How it works
// RULE1 - Flags: sign 7, zero 6, half 4, parity/overflow 2, subtract 1, carry 0.
// RULE2 - Primary and alternate flag registers; bits 3 and 5 carry no status.
// RULE3 - Only carry, parity/overflow, zero and sign are offered as branch conditions.
// RULE4 - Carry is set on add carry-out or subtract borrow, cleared otherwise.
// RULE5 - Decimal adjust sets carry when decimal correction of upper digit is needed.
// RULE6 - Left circular rotates and left shift put old bit 7 into carry.
// RULE7 - Right circular rotates and right shifts put old bit 0 into carry.
// RULE8 - Rotate-through-carry uses carry as ninth bit linking both byte ends.
// RULE9 - AND, OR and XOR clear carry.
// RULE10 - Set-carry forces carry to one; complement-carry inverts it.
// RULE11 - Subtract flag is cleared by additions and set by subtractions.
// RULE12 - Arithmetic parity/overflow flags signed results beyond +127 or -128.
// RULE13 - Add overflow only when like-signed operands give unlike-signed result.
// RULE14 - Subtract overflow only for unlike signs with result sign changed.
// RULE15 - Overflow equals carry into sign bit XOR carry out of it.
// RULE16 - Logic and rotate results put even parity (1 = even) in parity flag; the accumulator-only rotates leave the parity flag unchanged.
// RULE17 - Block move and search clear parity flag when counter reaches zero.
// RULE18 - Vector or refresh load copies interrupt enable shadow into parity flag.
// RULE19 - Register-indirect port input puts data parity into parity flag.
// RULE20 - Add sets half carry on carry from bit 3 into bit 4.
// RULE21 - Subtract sets half carry on borrow from bit 4.
// RULE22 - Zero flag set when the result byte is zero.
// RULE23 - Sign flag copies the result's most significant bit.
// RULE24 - Unaffected flags keep values; only the primary register takes results.
// RULE25 - Bits 3 and 5 are stored on writes; their post-operation value is undefined.
module status_flag_logic (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Operation from the decoder and datapath
  input wire logic op_valid,
  input wire flag_pkg::flag_op_t op_code,
  input wire logic [7:0] operand_a,
  input wire logic [7:0] operand_b,
  input wire logic [7:0] data_in,
  input wire logic counter_zero,
  input wire logic interrupt_enable_shadow,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Results and conditions
  output logic [7:0] result_q,
  output logic [7:0] flags_q,
  output logic cond_carry_q,
  output logic cond_parity_q,
  output logic cond_zero_q,
  output logic cond_sign_q
);
  import flag_pkg::*;

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] primary_q;
  logic [7:0] alternate_q;
  logic [7:0] primary_d;
  logic [7:0] alternate_d;
  logic primary_load;
  logic alternate_load;
  logic [7:0] result_d;

  // Two instances of the same storage cell RULE2
  flag_reg u_primary (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(primary_load),
    .d(primary_d),
    .q(primary_q)
  );

  flag_reg u_alternate (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(alternate_load),
    .d(alternate_d),
    .q(alternate_q)
  );

  // ****************************************
  // Arithmetic
  // ****************************************
  logic carry_in;
  logic is_sub;
  logic [7:0] b_eff;
  logic [4:0] low_sum;
  logic [3:0] mid_sum;
  logic [1:0] top_sum;
  logic [7:0] arith_res;
  logic carry_out;
  logic carry_sign_in;
  logic half_out;

  // Carry input and operand inversion for subtraction
  always_comb begin
    is_sub = (op_code == OP_SUB) || (op_code == OP_SBC) || (op_code == OP_BLOCK_SEARCH);
    carry_in = 1'b0;
    if (op_code == OP_ADC) begin
      carry_in = primary_q[BIT_CARRY];
    end else if ((op_code == OP_SUB) || (op_code == OP_BLOCK_SEARCH)) begin
      carry_in = 1'b1;
    end else if (op_code == OP_SBC) begin
      carry_in = ~primary_q[BIT_CARRY];
    end
    b_eff = is_sub ? ~operand_b : operand_b;
  end

  // Sliced adder exposes carries at bit 4, bit 7 and out of the byte
  assign low_sum = {1'b0, operand_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, carry_in};
  assign mid_sum = {1'b0, operand_a[6:4]} + {1'b0, b_eff[6:4]} + {3'h0, low_sum[4]};
  assign top_sum = {1'b0, operand_a[7]} + {1'b0, b_eff[7]} + {1'b0, mid_sum[3]};
  assign arith_res = {top_sum[0], mid_sum[2:0], low_sum[3:0]};
  assign carry_sign_in = mid_sum[3];
  // Borrow is the inverted carry on subtraction RULE4
  assign carry_out = is_sub ? ~top_sum[1] : top_sum[1];
  // Half borrow is the inverted nibble carry RULE20 RULE21
  assign half_out = is_sub ? ~low_sum[4] : low_sum[4];

  // ****************************************
  // Decimal adjust
  // ****************************************
  logic da_low;
  logic da_high;
  logic [7:0] da_corr;
  logic [7:0] da_res;

  // Correction chosen by the stored subtract, half-carry and carry flags
  always_comb begin
    da_low = primary_q[BIT_HALF] || (operand_a[3:0] > 4'h9);
    da_high = primary_q[BIT_CARRY] || (operand_a > 8'h99);
    da_corr = {(da_high ? 4'h6 : 4'h0), (da_low ? 4'h6 : 4'h0)};
    da_res = primary_q[BIT_SUB] ? (operand_a - da_corr) : (operand_a + da_corr);
  end

  // ****************************************
  // Flag computation
  // ****************************************
  logic [7:0] next_f;
  logic [7:0] res;
  logic write_res;

  // Default keeps every flag, each operation overrides its own RULE24
  always_comb begin
    next_f = primary_q;
    res = operand_a;
    write_res = 1'b1;
    case (op_code)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
        res = arith_res;
        next_f[BIT_CARRY] = carry_out; // RULE4
        next_f[BIT_HALF] = half_out; // RULE20 RULE21
        next_f[BIT_SUB] = is_sub; // RULE11
        // Carry into sign XOR carry out covers both sign cases RULE12 RULE13 RULE14 RULE15
        next_f[BIT_PARITY] = carry_sign_in ^ top_sum[1];
      end
      OP_AND, OP_OR, OP_XOR: begin
        if (op_code == OP_AND) begin
          res = operand_a & operand_b;
        end else if (op_code == OP_OR) begin
          res = operand_a | operand_b;
        end else begin
          res = operand_a ^ operand_b;
        end
        next_f[BIT_CARRY] = 1'b0; // RULE9
        next_f[BIT_HALF] = (op_code == OP_AND);
        next_f[BIT_SUB] = 1'b0;
        next_f[BIT_PARITY] = ~^res; // RULE16
      end
      OP_DECIMAL_ADJUST: begin
        res = da_res;
        next_f[BIT_CARRY] = da_high; // RULE5
        next_f[BIT_HALF] = primary_q[BIT_SUB] ? (primary_q[BIT_HALF] && operand_a[3:0] < 4'h6) :
                           (operand_a[3:0] > 4'h9);
        next_f[BIT_PARITY] = ~^da_res;
      end
      OP_SET_CARRY: begin
        write_res = 1'b0;
        next_f[BIT_CARRY] = 1'b1; // RULE10
        next_f[BIT_HALF] = 1'b0;
        next_f[BIT_SUB] = 1'b0;
      end
      OP_COMPLEMENT_CARRY: begin
        write_res = 1'b0;
        next_f[BIT_CARRY] = ~primary_q[BIT_CARRY]; // RULE10
        next_f[BIT_HALF] = primary_q[BIT_CARRY];
        next_f[BIT_SUB] = 1'b0;
      end
      OP_ACC_ROT_LEFT_CIRC, OP_ROT_LEFT_CIRC, OP_ARITH_SHIFT_LEFT: begin
        res = (op_code == OP_ARITH_SHIFT_LEFT) ? {operand_a[6:0], 1'b0} : {operand_a[6:0], operand_a[7]};
        next_f[BIT_CARRY] = operand_a[7]; // RULE6
        next_f[BIT_HALF] = 1'b0;
        next_f[BIT_SUB] = 1'b0;
      end
      OP_ACC_ROT_RIGHT_CIRC, OP_ROT_RIGHT_CIRC, OP_ARITH_SHIFT_RIGHT, OP_LOGIC_SHIFT_RIGHT: begin
        if (op_code == OP_ARITH_SHIFT_RIGHT) begin
          res = {operand_a[7], operand_a[7:1]};
        end else if (op_code == OP_LOGIC_SHIFT_RIGHT) begin
          res = {1'b0, operand_a[7:1]};
        end else begin
          res = {operand_a[0], operand_a[7:1]};
        end
        next_f[BIT_CARRY] = operand_a[0]; // RULE7
        next_f[BIT_HALF] = 1'b0;
        next_f[BIT_SUB] = 1'b0;
      end
      OP_ACC_ROT_LEFT_THROUGH, OP_ROT_LEFT_THROUGH: begin
        res = {operand_a[6:0], primary_q[BIT_CARRY]}; // RULE8
        next_f[BIT_CARRY] = operand_a[7]; // RULE8
        next_f[BIT_HALF] = 1'b0;
        next_f[BIT_SUB] = 1'b0;
      end
      OP_ACC_ROT_RIGHT_THROUGH, OP_ROT_RIGHT_THROUGH: begin
        res = {primary_q[BIT_CARRY], operand_a[7:1]}; // RULE8
        next_f[BIT_CARRY] = operand_a[0]; // RULE8
        next_f[BIT_HALF] = 1'b0;
        next_f[BIT_SUB] = 1'b0;
      end
      OP_BLOCK_MOVE: begin
        write_res = 1'b0;
        next_f[BIT_PARITY] = ~counter_zero; // RULE17
        next_f[BIT_HALF] = 1'b0;
        next_f[BIT_SUB] = 1'b0;
      end
      OP_BLOCK_SEARCH: begin
        write_res = 1'b0;
        res = arith_res;
        next_f[BIT_PARITY] = ~counter_zero; // RULE17
        next_f[BIT_HALF] = ~low_sum[4];
        next_f[BIT_SUB] = 1'b1;
      end
      OP_LOAD_VECTOR_REFRESH: begin
        res = data_in;
        next_f[BIT_PARITY] = interrupt_enable_shadow; // RULE18
        next_f[BIT_HALF] = 1'b0;
        next_f[BIT_SUB] = 1'b0;
      end
      OP_PORT_INPUT: begin
        res = data_in;
        next_f[BIT_PARITY] = ~^data_in; // RULE19
        next_f[BIT_HALF] = 1'b0;
        next_f[BIT_SUB] = 1'b0;
      end
      default: begin
        write_res = 1'b0;
      end
    endcase
    // Sign and zero follow the result; the accumulator-only rotates and carry ops leave them
    if (write_res || op_code == OP_BLOCK_SEARCH) begin
      if (!(op_code inside {OP_ACC_ROT_LEFT_CIRC, OP_ACC_ROT_RIGHT_CIRC,
                            OP_ACC_ROT_LEFT_THROUGH, OP_ACC_ROT_RIGHT_THROUGH})) begin
        next_f[BIT_SIGN] = res[7]; // RULE23
        next_f[BIT_ZERO] = (res == 8'h00); // RULE22
        if (op_code inside {OP_ROT_LEFT_CIRC, OP_ROT_RIGHT_CIRC, OP_ROT_LEFT_THROUGH,
                            OP_ROT_RIGHT_THROUGH, OP_ARITH_SHIFT_LEFT, OP_ARITH_SHIFT_RIGHT,
                            OP_LOGIC_SHIFT_RIGHT}) begin
          next_f[BIT_PARITY] = ~^res; // RULE16
        end
      end
    end
    // Unused positions simply hold their old contents RULE25
    next_f[BIT_UNUSED_HI] = primary_q[BIT_UNUSED_HI];
    next_f[BIT_UNUSED_LO] = primary_q[BIT_UNUSED_LO];
  end

  // ****************************************
  // Register loads
  // ****************************************
  logic exchange;
  assign exchange = op_valid && (op_code == OP_EXCHANGE);

  // Software write wins over an instruction in the same cycle; results touch only primary RULE24
  always_comb begin
    primary_load = 1'b0;
    primary_d = next_f;
    alternate_load = 1'b0;
    alternate_d = reg_wdata;
    if (reg_write && reg_addr == ADDR_PRIMARY) begin
      primary_load = 1'b1;
      primary_d = reg_wdata; // RULE25
    end else if (exchange) begin
      primary_load = 1'b1;
      primary_d = alternate_q;
    end else if (op_valid) begin
      primary_load = 1'b1;
    end
    if (reg_write && reg_addr == ADDR_ALTERNATE) begin
      alternate_load = 1'b1; // RULE25
    end else if (exchange) begin
      alternate_load = 1'b1;
      alternate_d = primary_q;
    end
  end

  // Result byte register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      result_q <= 8'h00;
    end else if (op_valid && write_res) begin
      result_q <= res;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Registered copy of the primary flags and the four testable conditions RULE1 RULE3
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flags_q <= FLAGS_RESET;
      cond_carry_q <= 1'b0;
      cond_parity_q <= 1'b0;
      cond_zero_q <= 1'b0;
      cond_sign_q <= 1'b0;
    end else begin
      flags_q <= primary_load ? primary_d : primary_q;
      cond_carry_q <= primary_load ? primary_d[BIT_CARRY] : primary_q[BIT_CARRY]; // RULE3
      cond_parity_q <= primary_load ? primary_d[BIT_PARITY] : primary_q[BIT_PARITY]; // RULE3
      cond_zero_q <= primary_load ? primary_d[BIT_ZERO] : primary_q[BIT_ZERO]; // RULE3
      cond_sign_q <= primary_load ? primary_d[BIT_SIGN] : primary_q[BIT_SIGN]; // RULE3
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        ADDR_PRIMARY: reg_rdata <= primary_q;
        ADDR_ALTERNATE: reg_rdata <= alternate_q;
        ADDR_CONDITIONS: reg_rdata <= {4'h0, primary_q[BIT_SIGN], primary_q[BIT_ZERO],
                                       primary_q[BIT_PARITY], primary_q[BIT_CARRY]};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : status_flag_logic

// [flag_pkg.sv]
package flag_pkg;
  // ****************************************
  // Flag bit positions
  // ****************************************
  localparam int BIT_SIGN = 7;
  localparam int BIT_ZERO = 6;
  localparam int BIT_UNUSED_HI = 5;
  localparam int BIT_HALF = 4;
  localparam int BIT_UNUSED_LO = 3;
  localparam int BIT_PARITY = 2;
  localparam int BIT_SUB = 1;
  localparam int BIT_CARRY = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] MSB_MASK = 8'h80;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [1:0] ADDR_PRIMARY = 2'h0;
  localparam logic [1:0] ADDR_ALTERNATE = 2'h1;
  localparam logic [1:0] ADDR_CONDITIONS = 2'h2;

  // ****************************************
  // Operation codes from the decoder
  // ****************************************
  typedef enum logic [4:0] {
    OP_NONE,
    OP_ADD,
    OP_ADC,
    OP_SUB,
    OP_SBC,
    OP_AND,
    OP_OR,
    OP_XOR,
    OP_DECIMAL_ADJUST,
    OP_SET_CARRY,
    OP_COMPLEMENT_CARRY,
    OP_ACC_ROT_LEFT_CIRC,
    OP_ACC_ROT_RIGHT_CIRC,
    OP_ACC_ROT_LEFT_THROUGH,
    OP_ACC_ROT_RIGHT_THROUGH,
    OP_ROT_LEFT_CIRC,
    OP_ROT_RIGHT_CIRC,
    OP_ROT_LEFT_THROUGH,
    OP_ROT_RIGHT_THROUGH,
    OP_ARITH_SHIFT_LEFT,
    OP_ARITH_SHIFT_RIGHT,
    OP_LOGIC_SHIFT_RIGHT,
    OP_BLOCK_MOVE,
    OP_BLOCK_SEARCH,
    OP_LOAD_VECTOR_REFRESH,
    OP_PORT_INPUT,
    OP_EXCHANGE
  } flag_op_t;
endpackage : flag_pkg

// [flag_reg.sv]
`timescale 1ns/1ps
// Eight-bit storage element for one flag register
module flag_reg (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Load port
  input wire logic load,
  input wire logic [7:0] d,
  // Stored value
  output logic [7:0] q
);
  import flag_pkg::*;

  // Loads all eight bits, unused positions included
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= FLAGS_RESET;
    end else if (load) begin
      q <= d;
    end
  end
endmodule : flag_reg

// [status_flag_props.sv]
`timescale 1ns/1ps
// Checker for the flag logic, bound to its ports
module status_flag_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Operation
  input wire logic op_valid,
  input wire flag_pkg::flag_op_t op_code,
  input wire logic [7:0] operand_a,
  input wire logic [7:0] operand_b,
  input wire logic [7:0] data_in,
  input wire logic counter_zero,
  input wire logic interrupt_enable_shadow,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Results and conditions
  input wire logic [7:0] result_q,
  input wire logic [7:0] flags_q,
  input wire logic cond_carry_q,
  input wire logic cond_parity_q,
  input wire logic cond_zero_q,
  input wire logic cond_sign_q
);
  import flag_pkg::*;
  logic op_ok;
  // Operation that a primary write does not override
  assign op_ok = op_valid && !(reg_write && reg_addr == ADDR_PRIMARY);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  prim_read_a: assert property (reg_read && reg_addr == ADDR_PRIMARY |=> reg_rdata == $past(flags_q))
    else $error("primary read data wrong");
  cond_read_a: assert property (reg_read && reg_addr == ADDR_CONDITIONS |=> reg_rdata ==
    {4'h0, $past(flags_q[7]), $past(flags_q[6]), $past(flags_q[2]), $past(flags_q[0])})
    else $error("condition read data wrong");
  cond_map_a: assert property (cond_carry_q == flags_q[BIT_CARRY] && cond_parity_q == flags_q[BIT_PARITY] &&
    cond_zero_q == flags_q[BIT_ZERO] && cond_sign_q == flags_q[BIT_SIGN]) else $error("condition outputs wrong");
  write_store_a: assert property (reg_write && reg_addr == ADDR_PRIMARY |=> flags_q == $past(reg_wdata))
    else $error("primary write not stored");
  idle_hold_a: assert property (!op_valid && !reg_write |=> $stable(flags_q))
    else $error("flags changed without cause");
  logic_carry_a: assert property (op_ok && op_code inside {OP_AND, OP_OR, OP_XOR} |=> !flags_q[BIT_CARRY])
    else $error("logic op left carry set");
  set_carry_a: assert property (op_ok && op_code == OP_SET_CARRY |=> flags_q[BIT_CARRY])
    else $error("set carry failed");
  comp_carry_a: assert property (op_ok && op_code == OP_COMPLEMENT_CARRY |=>
    flags_q[BIT_CARRY] != $past(flags_q[BIT_CARRY])) else $error("complement carry failed");
  sub_flag_a: assert property (op_ok && op_code inside {OP_SUB, OP_SBC} |=> flags_q[BIT_SUB])
    else $error("subtract flag not set");
  add_carry_a: assert property (op_ok && op_code == OP_ADD |=> flags_q[BIT_CARRY] ==
    (({1'b0, $past(operand_a)} + {1'b0, $past(operand_b)}) > 9'h0FF)) else $error("add carry wrong");
  zero_sign_a: assert property (op_ok && op_code inside {OP_ADD, OP_SUB, OP_AND} |=>
    flags_q[BIT_ZERO] == (result_q == 8'h00) && flags_q[BIT_SIGN] == result_q[7]) else $error("zero or sign wrong");
endmodule : status_flag_props

// [datapath_model.sv]
`timescale 1ns/1ps
// Decoder and datapath stand-in: one op_valid pulse per instruction
module datapath_model (
  // Clock
  input wire logic clk_sys,
  // Operation toward the flag logic
  output logic op_valid,
  output flag_pkg::flag_op_t op_code,
  output logic [7:0] operand_a,
  output logic [7:0] operand_b,
  output logic [7:0] data_in,
  output logic counter_zero,
  output logic interrupt_enable_shadow
);
  import flag_pkg::*;
  // Idle values at time zero
  initial begin
    op_valid = 1'b0;
    op_code = OP_NONE;
    {operand_a, operand_b, data_in, counter_zero, interrupt_enable_shadow} = '0;
  end
  // One instruction for one cycle, then operands scrambled so stale values never pass
  task automatic issue(input flag_op_t op, input logic [7:0] a, b, d, input logic cz, ie);
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_code <= op;
    operand_a <= a;
    operand_b <= b;
    data_in <= d;
    counter_zero <= cz;
    interrupt_enable_shadow <= ie;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    operand_a <= ~a;
    operand_b <= ~b;
    data_in <= ~d;
  endtask : issue
endmodule : datapath_model

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import flag_pkg::*;
  logic clk_sys, rst_n, reg_write, reg_read, op_valid, counter_zero, interrupt_enable_shadow;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, operand_a, operand_b, data_in, result_q, flags_q, v;
  logic cond_carry_q, cond_parity_q, cond_zero_q, cond_sign_q;
  flag_op_t op_code;
  int num_errors = 0;
  int compares = 0;
  flag_op_t cop [8] = '{OP_ADD, OP_SUB, OP_ADD, OP_SBC, OP_ADC, OP_ACC_ROT_RIGHT_THROUGH, OP_DECIMAL_ADJUST,
    OP_BLOCK_SEARCH};
  logic [7:0] ca [8] = '{8'h78, 8'h7F, 8'h80, 8'h00, 8'hFF, 8'h01, 8'h9A, 8'h00};
  logic [7:0] cb [8] = '{8'h69, 8'hC0, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] cf [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  datapath_model dp (.clk_sys(clk_sys), .op_valid(op_valid), .op_code(op_code), .operand_a(operand_a),
    .operand_b(operand_b), .data_in(data_in), .counter_zero(counter_zero),
    .interrupt_enable_shadow(interrupt_enable_shadow));
  status_flag_logic uut (.clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
    .operand_a(operand_a), .operand_b(operand_b), .data_in(data_in), .counter_zero(counter_zero),
    .interrupt_enable_shadow(interrupt_enable_shadow), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .result_q(result_q), .flags_q(flags_q),
    .cond_carry_q(cond_carry_q), .cond_parity_q(cond_parity_q), .cond_zero_q(cond_zero_q),
    .cond_sign_q(cond_sign_q));
  // Expected flags, result and mask of flags that the operation defines
  function automatic logic [7:0] ref_f(input flag_op_t op, input logic [7:0] a, b, d, f,
    input logic cz, ie, output logic [7:0] r, output logic [7:0] m, output logic rc);
    logic [8:0] s;
    logic ci, h, ov;
    logic [7:0] e;
    e = f;
    r = 8'h00;
    m = 8'hC5;
    rc = 1'b0;
    ci = (op == OP_ADC || op == OP_SBC) && f[0];
    case (op)
      OP_ADD, OP_ADC: begin
        s = {1'b0, a} + {1'b0, b} + 9'(ci);
        h = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci)) > 5'h0F;
        ov = a[7] == b[7] && s[7] != a[7];
        e = {s[7], s[7:0] == 8'h00, f[5], h, f[3], ov, 1'b0, s[8]};
        {r, m, rc} = {s[7:0], 8'hD7, 1'b1};
      end
      OP_SUB, OP_SBC: begin
        s = {1'b0, a} - {1'b0, b} - 9'(ci);
        h = {1'b0, a[3:0]} < {1'b0, b[3:0]} + 5'(ci);
        ov = a[7] != b[7] && s[7] != a[7];
        e = {s[7], s[7:0] == 8'h00, f[5], h, f[3], ov, 1'b1, s[8]};
        {r, m, rc} = {s[7:0], 8'hD7, 1'b1};
      end
      OP_AND, OP_OR, OP_XOR: begin
        r = op == OP_AND ? a & b : op == OP_OR ? a | b : a ^ b;
        e = {r[7], r == 8'h00, f[5:3], ~^r, f[1], 1'b0};
        rc = 1'b1;
      end
      OP_SET_CARRY: e[0] = 1'b1;
      OP_COMPLEMENT_CARRY: e[0] = ~f[0];
      OP_DECIMAL_ADJUST: {e[0], m} = {f[0] | (a > 8'h99), 8'h01};
      OP_BLOCK_MOVE: {e[2], m} = {~cz, 8'h04};
      OP_BLOCK_SEARCH: begin
        s = {1'b0, a} - {1'b0, b};
        e = {s[7], s[7:0] == 8'h00, f[5], a[3:0] < b[3:0], f[3], ~cz, 1'b1, f[0]};
        m = 8'hD7;
      end
      OP_LOAD_VECTOR_REFRESH: {e[2], m} = {ie, 8'h04};
      OP_PORT_INPUT: {e, m} = {d[7], d == 8'h00, f[5:3], ~^d, f[1:0], 8'hC4};
      default: begin
        case (op)
          OP_ACC_ROT_LEFT_CIRC, OP_ROT_LEFT_CIRC: r = {a[6:0], a[7]};
          OP_ACC_ROT_RIGHT_CIRC, OP_ROT_RIGHT_CIRC: r = {a[0], a[7:1]};
          OP_ACC_ROT_LEFT_THROUGH, OP_ROT_LEFT_THROUGH: r = {a[6:0], f[0]};
          OP_ACC_ROT_RIGHT_THROUGH, OP_ROT_RIGHT_THROUGH: r = {f[0], a[7:1]};
          OP_ARITH_SHIFT_LEFT: r = {a[6:0], 1'b0};
          OP_ARITH_SHIFT_RIGHT: r = {a[7], a[7:1]};
          default: r = {1'b0, a[7:1]};
        endcase
        e = {r[7], r == 8'h00, f[5:3], ~^r, f[1], op inside {OP_ACC_ROT_LEFT_CIRC, OP_ROT_LEFT_CIRC,
          OP_ACC_ROT_LEFT_THROUGH, OP_ROT_LEFT_THROUGH, OP_ARITH_SHIFT_LEFT} ? a[7] : a[0]};
        m = op inside {OP_ACC_ROT_LEFT_CIRC, OP_ACC_ROT_RIGHT_CIRC, OP_ACC_ROT_LEFT_THROUGH,
          OP_ACC_ROT_RIGHT_THROUGH} ? 8'h01 : 8'hC5;
        rc = 1'b1;
      end
    endcase
    return e;
  endfunction : ref_f
  task automatic check(input string nm, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic reg_wr(input logic [1:0] ad, input logic [7:0] wd);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_wdata <= wd;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [1:0] ad, output logic [7:0] rd);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask : reg_rd
  // Load primary flags, issue one operation, compare defined flags, conditions and result
  task automatic run_op(input flag_op_t op, input logic [7:0] a, b, d, f, input logic cz, ie);
    logic [7:0] e, r, m;
    logic rc;
    e = ref_f(op, a, b, d, f, cz, ie, r, m, rc);
    reg_wr(ADDR_PRIMARY, f);
    dp.issue(op, a, b, d, cz, ie);
    #1;
    check("flags", flags_q & m, e & m);
    check("conds", {4'h0, cond_sign_q, cond_zero_q, cond_parity_q, cond_carry_q} & {4'h0, m[7:6], m[2], m[0]},
      {4'h0, e[7:6], e[2], e[0]} & {4'h0, m[7:6], m[2], m[0]});
    if (rc) check("result", result_q, r);
  endtask : run_op
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    results();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    void'($urandom(32'h6982dc6e));
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      reg_rd(2'(i), v);
      check("reset", v, 8'h00);
    end
    reg_wr(ADDR_PRIMARY, 8'h3C);
    reg_wr(ADDR_ALTERNATE, 8'hC3);
    reg_wr(2'h3, 8'hFF);
    reg_rd(2'h3, v);
    check("unmapped", v, 8'h00);
    reg_rd(ADDR_CONDITIONS, v);
    check("cond_reg", v, 8'h02);
    reg_rd(ADDR_PRIMARY, v);
    check("primary", v, 8'h3C);
    dp.issue(OP_EXCHANGE, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
    #1;
    check("exchange", flags_q, 8'hC3);
    reg_rd(ADDR_ALTERNATE, v);
    check("alternate", v, 8'h3C);
    fork
      dp.issue(OP_SET_CARRY, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
      reg_wr(ADDR_PRIMARY, 8'h28);
    join
    #1;
    check("write_wins", flags_q, 8'h28);
    for (int i = 0; i < 8; i++) begin
      run_op(cop[i], ca[i], cb[i], 8'h00, cf[i], i == 7, 1'b0);
    end
    for (int i = 0; i < 300; i++) begin
      run_op(flag_op_t'($urandom_range(25, 1)), 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom),
        1'($urandom), 1'($urandom));
    end
    results();
  end
endmodule : tb_top
bind status_flag_logic status_flag_props u_props (.clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid),
  .op_code(op_code), .operand_a(operand_a), .operand_b(operand_b), .data_in(data_in),
  .counter_zero(counter_zero), .interrupt_enable_shadow(interrupt_enable_shadow), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .result_q(result_q), .flags_q(flags_q), .cond_carry_q(cond_carry_q), .cond_parity_q(cond_parity_q),
  .cond_zero_q(cond_zero_q), .cond_sign_q(cond_sign_q));
